// [osd_pkg.sv]
// Constants, register layout and carrier types for the oscillator
// select and clock divider block.
// Assumes a 16-bit register port in a single 125 MHz clock domain.

package osd_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] OSD_ADDR_OSC_CTRL = 4'h0;
	localparam logic [3:0] OSD_ADDR_CLK_DIV = 4'h1;
	localparam logic [3:0] OSD_ADDR_STATUS = 4'h2;

	// oscillator_control field positions
	localparam int OSD_CUR_LSB = 12;
	localparam int OSD_NEW_LSB = 8;
	localparam int OSD_SEL_LOCK_BIT = 7;
	localparam int OSD_PIN_LOCK_BIT = 6;
	localparam int OSD_PLL_LOCK_BIT = 5;
	localparam int OSD_FAIL_BIT = 3;
	localparam int OSD_PRI_SLEEP_BIT = 2;
	localparam int OSD_SEC_EN_BIT = 1;
	localparam int OSD_SWITCH_BIT = 0;

	// clock_divider_control field positions
	localparam int OSD_ROI_BIT = 15;
	localparam int OSD_DOZE_LSB = 12;
	localparam int OSD_CPU_SLOWDOWN_ENABLE_BIT = 11;
	localparam int OSD_INTERNAL_RC_POSTSCALER_LSB = 8;
	localparam int OSD_SYSTEM_CLOCK_POSTSCALER_LSB = 6;
	localparam int OSD_PLL_ALWAYS_ON_BIT = 5;

	// Reset values and RC postscaler limits
	localparam logic [2:0] OSD_DOZE_RST = 3'h3;
	localparam logic [2:0] OSD_INTERNAL_RC_POSTSCALER_RST = 3'h1;
	localparam logic [2:0] OSD_INTERNAL_RC_POSTSCALER_MAX = 3'h7;
	localparam logic [7:0] OSD_INTERNAL_RC_POSTSCALER_DIV256 = 8'hff;

	// ==========================================================
	// Source encodings
	typedef enum logic [2:0] {
		OSD_SRC_FRC = 3'b000,
		OSD_SRC_FRC_PLL = 3'b001,
		OSD_SRC_PRI = 3'b010,
		OSD_SRC_PRI_PLL = 3'b011,
		OSD_SRC_SEC = 3'b100,
		OSD_SRC_LOW_POWER_INTERNAL_RC = 3'b101,
		OSD_SRC_RSVD = 3'b110,
		OSD_SRC_FRC_DIV = 3'b111
	} osd_src_t;

	// Primary oscillator modes
	typedef enum logic [1:0] {
		OSD_PRI_EXT = 2'b00,
		OSD_PRI_XTAL = 2'b01,
		OSD_PRI_HS = 2'b10,
		OSD_PRI_OFF = 2'b11
	} osd_pri_mode_t;

	// Switch sequencer
	typedef enum logic [1:0] {
		OSD_SW_IDLE = 2'b00,
		OSD_SW_WAIT = 2'b01,
		OSD_SW_DONE = 2'b10
	} osd_sw_state_t;

	// PLL start-up timer, in ns and in cycles at 8 ns
	localparam int OSD_CLK_NS = 8;
	localparam int OSD_PLL_START_NS = 2000;
	localparam int OSD_PLL_START_CYC = OSD_PLL_START_NS / OSD_CLK_NS;
	localparam int OSD_SWITCH_CYC = 4;

	// Configuration word fields
	typedef struct packed {
		logic [1:0] switch_monitor_config;
		osd_pri_mode_t primary_osc_mode_config;
		osd_src_t initial_osc_select_config;
		logic one_way_pinmap_lock_config;
	} osd_cfg_t;

	// Clock outputs to the analog and clock tree
	typedef struct packed {
		osd_src_t active_source;
		logic pll_enable;
		logic primary_run;
		logic secondary_enable;
		logic [2:0] cpu_ratio_log2;
		logic [7:0] rc_divisor_m1;
		logic [2:0] sys_divisor_m1;
		logic failsafe_clock_monitor;
		logic pin_mapping_lock;
	} osd_clk_ctl_t;

endpackage

// [osd_clock_ctrl.sv]
// Oscillator select and clock divider control: registers, switch
// sequencer, PLL lock timer and clock-tree control outputs.
// Assumes config word, unlock and event inputs are synchronous to sys_clk,
// and asynchronous analog indications arrive on pll_locked_async and
// clock_fail_async.
`timescale 1ns/1ps
`default_nettype none

module osd_clock_ctrl #(
	parameter int PLL_START_CYC = osd_pkg::OSD_PLL_START_CYC,
	parameter int SWITCH_CYC = osd_pkg::OSD_SWITCH_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Non-volatile configuration
	input wire osd_pkg::osd_cfg_t cfg,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Unlock state of the control register and the pin map
	input wire logic osc_write_unlocked,
	input wire logic pinmap_unlocked,
	// System events
	input wire logic interrupt_event,
	input wire logic sleep_mode,
	input wire logic usb_enabled,
	input wire logic pll_locked_async,
	input wire logic clock_fail_async,
	// Clock tree control
	output osd_pkg::osd_clk_ctl_t clk_ctl
);

	// ==========================================================
	// State
	typedef struct packed {
		logic cfg_loaded;
		osd_pkg::osd_src_t cur_src;
		osd_pkg::osd_src_t new_src;
		logic sel_lock;
		logic pin_lock;
		logic pll_lock;
		logic clk_fail;
		logic pri_sleep_en;
		logic sec_en;
		logic sw_req;
		osd_pkg::osd_sw_state_t sw_state;
		logic [15:0] sw_cnt;
		logic [15:0] pll_cnt;
		logic recover_on_interrupt;
		logic [2:0] doze;
		logic cpu_slowdown_enable;
		logic [2:0] internal_rc_postscaler;
		logic [1:0] system_clock_postscaler;
		logic pll_always_on;
		logic [1:0] pll_sync;
		logic [1:0] fail_sync;
		logic [15:0] rdata;
		osd_pkg::osd_clk_ctl_t ctl;
	} osd_state_t;

	osd_state_t st_r;
	osd_state_t st_nxt;

	// ==========================================================
	// Helpers

	// True for sources that run through the PLL
	function automatic logic osd_is_pll(input osd_pkg::osd_src_t s);
		return (s == osd_pkg::OSD_SRC_PRI_PLL) ||
			(s == osd_pkg::OSD_SRC_FRC_PLL);
	endfunction

	// RC postscaler divisor minus one: 2^n, except 111 gives 256
	function automatic logic [7:0] osd_rc_div_m1(input logic [2:0] n);
		if (n == osd_pkg::OSD_INTERNAL_RC_POSTSCALER_MAX)
			return osd_pkg::OSD_INTERNAL_RC_POSTSCALER_DIV256;
		return 8'((9'h1 << n) - 9'h1);
	endfunction

	// Combined read-back images
	function automatic logic [15:0] osd_osc_img(input osd_state_t s);
		logic [15:0] v;
		v = 16'h0000;
		v[osd_pkg::OSD_CUR_LSB +: 3] = s.cur_src;
		v[osd_pkg::OSD_NEW_LSB +: 3] = s.new_src;
		v[osd_pkg::OSD_SEL_LOCK_BIT] = s.sel_lock;
		v[osd_pkg::OSD_PIN_LOCK_BIT] = s.pin_lock;
		v[osd_pkg::OSD_PLL_LOCK_BIT] = s.pll_lock;
		v[osd_pkg::OSD_FAIL_BIT] = s.clk_fail;
		v[osd_pkg::OSD_PRI_SLEEP_BIT] = s.pri_sleep_en;
		v[osd_pkg::OSD_SEC_EN_BIT] = s.sec_en;
		v[osd_pkg::OSD_SWITCH_BIT] = s.sw_req;
		return v;
	endfunction

	function automatic logic [15:0] osd_div_img(input osd_state_t s);
		logic [15:0] v;
		v = 16'h0000;
		v[osd_pkg::OSD_ROI_BIT] = s.recover_on_interrupt;
		v[osd_pkg::OSD_DOZE_LSB +: 3] = s.doze;
		v[osd_pkg::OSD_CPU_SLOWDOWN_ENABLE_BIT] = s.cpu_slowdown_enable;
		v[osd_pkg::OSD_INTERNAL_RC_POSTSCALER_LSB +: 3] = s.internal_rc_postscaler;
		v[osd_pkg::OSD_SYSTEM_CLOCK_POSTSCALER_LSB +: 2] = s.system_clock_postscaler;
		v[osd_pkg::OSD_PLL_ALWAYS_ON_BIT] = s.pll_always_on;
		return v;
	endfunction

	// ==========================================================
	// Derived configuration
	logic switch_allowed;
	logic monitor_on;
	logic sel_frozen;
	logic wr_osc;
	logic wr_div;
	logic pll_sync_q;
	logic fail_sync_q;
	logic pll_wanted;

	// Config bit decode
	always_comb
	begin
		switch_allowed = ~cfg.switch_monitor_config[1];
		monitor_on = (cfg.switch_monitor_config == 2'b00);
		// Lock only counts when the upper config bit is one
		sel_frozen = cfg.switch_monitor_config[1] & st_r.sel_lock;
		wr_osc = reg_wr && (reg_addr == osd_pkg::OSD_ADDR_OSC_CTRL) &&
			osc_write_unlocked;
		wr_div = reg_wr && (reg_addr == osd_pkg::OSD_ADDR_CLK_DIV);
		pll_sync_q = st_r.pll_sync[1];
		fail_sync_q = st_r.fail_sync[1];
		pll_wanted = st_r.pll_always_on | osd_is_pll(st_r.cur_src);
	end

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		st_nxt = st_r;

		// Two-stage synchronisers for analog indications
		st_nxt.pll_sync = {st_r.pll_sync[0], pll_locked_async};
		st_nxt.fail_sync = {st_r.fail_sync[0], clock_fail_async};

		// First cycle after reset: take the power-on source from config
		if (!st_r.cfg_loaded)
		begin
			st_nxt.cfg_loaded = 1'b1;
			st_nxt.cur_src = cfg.initial_osc_select_config;
			st_nxt.new_src = cfg.initial_osc_select_config;
		end

		// oscillator_control writes
		if (wr_osc && st_r.cfg_loaded)
		begin
			if (!sel_frozen && st_r.sw_state == osd_pkg::OSD_SW_IDLE)
				st_nxt.new_src = osd_pkg::osd_src_t'(
					reg_wdata[osd_pkg::OSD_NEW_LSB +: 3]);
			// Selection lock is set-only
			if (reg_wdata[osd_pkg::OSD_SEL_LOCK_BIT])
				st_nxt.sel_lock = 1'b1;
			// Pin-map lock needs unlock; one-way config bars clearing
			if (pinmap_unlocked &&
				!(cfg.one_way_pinmap_lock_config && st_r.pin_lock))
				st_nxt.pin_lock = reg_wdata[osd_pkg::OSD_PIN_LOCK_BIT];
			// Clock-fail flag is clear-only
			if (!reg_wdata[osd_pkg::OSD_FAIL_BIT])
				st_nxt.clk_fail = 1'b0;
			st_nxt.pri_sleep_en = reg_wdata[osd_pkg::OSD_PRI_SLEEP_BIT];
			st_nxt.sec_en = reg_wdata[osd_pkg::OSD_SEC_EN_BIT];
			if (reg_wdata[osd_pkg::OSD_SWITCH_BIT] && switch_allowed &&
				!sel_frozen && st_r.sw_state == osd_pkg::OSD_SW_IDLE)
				st_nxt.sw_req = 1'b1;
		end

		// Monitor event wins over a software clear
		if (monitor_on && fail_sync_q)
			st_nxt.clk_fail = 1'b1;

		// clock_divider_control writes
		if (wr_div)
		begin
			st_nxt.recover_on_interrupt = reg_wdata[osd_pkg::OSD_ROI_BIT];
			st_nxt.doze = reg_wdata[osd_pkg::OSD_DOZE_LSB +: 3];
			st_nxt.cpu_slowdown_enable = reg_wdata[osd_pkg::OSD_CPU_SLOWDOWN_ENABLE_BIT];
			st_nxt.internal_rc_postscaler = reg_wdata[osd_pkg::OSD_INTERNAL_RC_POSTSCALER_LSB +: 3];
			st_nxt.system_clock_postscaler = reg_wdata[osd_pkg::OSD_SYSTEM_CLOCK_POSTSCALER_LSB +: 2];
			st_nxt.pll_always_on = reg_wdata[osd_pkg::OSD_PLL_ALWAYS_ON_BIT];
		end

		// Interrupt recovery wins over a write setting slowdown
		if (st_r.recover_on_interrupt && interrupt_event)
			st_nxt.cpu_slowdown_enable = 1'b0;

		// Switch sequencer: wait a fixed settle time, then commit
		case (st_r.sw_state)
			osd_pkg::OSD_SW_IDLE:
			begin
				if (st_r.sw_req)
				begin
					st_nxt.sw_state = osd_pkg::OSD_SW_WAIT;
					st_nxt.sw_cnt = 16'(SWITCH_CYC - 1);
					st_nxt.pll_lock = 1'b0;
				end
			end
			osd_pkg::OSD_SW_WAIT:
			begin
				if (st_r.sw_cnt == 16'h0000)
					st_nxt.sw_state = osd_pkg::OSD_SW_DONE;
				else
					st_nxt.sw_cnt = st_r.sw_cnt - 16'h0001;
			end
			osd_pkg::OSD_SW_DONE:
			begin
				st_nxt.cur_src = st_r.new_src;
				st_nxt.sw_req = 1'b0;
				st_nxt.sw_state = osd_pkg::OSD_SW_IDLE;
				st_nxt.pll_cnt = 16'(PLL_START_CYC);
			end
			default:
				st_nxt.sw_state = osd_pkg::OSD_SW_IDLE;
		endcase

		// PLL lock: locked or start-up timer expired, cleared otherwise
		if (st_r.sw_state != osd_pkg::OSD_SW_IDLE || st_r.sw_req)
			st_nxt.pll_lock = 1'b0;
		else if (!osd_is_pll(st_r.cur_src))
		begin
			st_nxt.pll_lock = 1'b0;
			st_nxt.pll_cnt = 16'(PLL_START_CYC);
		end
		else
		begin
			if (st_r.pll_cnt != 16'h0000)
				st_nxt.pll_cnt = st_r.pll_cnt - 16'h0001;
			st_nxt.pll_lock = pll_sync_q ||
				(st_r.pll_cnt == 16'h0000);
		end

		// Read data, valid the cycle after the strobe
		st_nxt.rdata = 16'h0000;
		if (reg_rd)
		begin
			case (reg_addr)
				osd_pkg::OSD_ADDR_OSC_CTRL:
					st_nxt.rdata = osd_osc_img(st_r);
				osd_pkg::OSD_ADDR_CLK_DIV:
					st_nxt.rdata = osd_div_img(st_r);
				osd_pkg::OSD_ADDR_STATUS:
					st_nxt.rdata = {8'h00, cfg.switch_monitor_config,
						cfg.primary_osc_mode_config, 1'b0,
						st_r.sw_state == osd_pkg::OSD_SW_IDLE,
						monitor_on, switch_allowed};
				default:
					st_nxt.rdata = 16'h0000;
			endcase
		end

		// Clock tree controls
		st_nxt.ctl.active_source = st_r.cur_src;
		st_nxt.ctl.pll_enable = pll_wanted;
		st_nxt.ctl.primary_run = (st_r.cur_src == osd_pkg::OSD_SRC_PRI ||
			st_r.cur_src == osd_pkg::OSD_SRC_PRI_PLL) &&
			(!sleep_mode || st_r.pri_sleep_en);
		st_nxt.ctl.secondary_enable = st_r.sec_en;
		st_nxt.ctl.cpu_ratio_log2 = st_r.cpu_slowdown_enable ? st_r.doze : 3'h0;
		st_nxt.ctl.rc_divisor_m1 = osd_rc_div_m1(st_r.internal_rc_postscaler);
		st_nxt.ctl.sys_divisor_m1 = 3'((4'h1 << st_r.system_clock_postscaler) - 4'h1);
		st_nxt.ctl.failsafe_clock_monitor = monitor_on;
		st_nxt.ctl.pin_mapping_lock = st_r.pin_lock;
		// With usb_enabled, codes 10/11 are not applied: sys_divisor_m1 keeps its value
		if (usb_enabled && st_r.system_clock_postscaler[1])
			st_nxt.ctl.sys_divisor_m1 = st_r.ctl.sys_divisor_m1;
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r <= '0;
			st_r.cur_src <= osd_pkg::OSD_SRC_FRC_DIV;
			st_r.new_src <= osd_pkg::OSD_SRC_FRC_DIV;
			st_r.doze <= osd_pkg::OSD_DOZE_RST;
			st_r.internal_rc_postscaler <= osd_pkg::OSD_INTERNAL_RC_POSTSCALER_RST;
			st_r.pll_cnt <= 16'(PLL_START_CYC);
			st_r.ctl.active_source <= osd_pkg::OSD_SRC_FRC_DIV;
			st_r.ctl.rc_divisor_m1 <= 8'h01;
		end
		else
			st_r <= st_nxt;
	end

	// Outputs straight from the state register
	assign reg_rdata = st_r.rdata;
	assign clk_ctl = st_r.ctl;

endmodule

`default_nettype wire

// [osd_clock_ctrl_monitor.sv]
// Port checker for the oscillator select and clock divider block.
// Assumes one sys_clk domain with async active-low resetn.
`timescale 1ns/1ps
`default_nettype none

module osd_clock_ctrl_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Observed ports
	input wire osd_pkg::osd_cfg_t cfg,
	input wire logic pinmap_unlocked,
	input wire logic usb_enabled,
	input wire osd_pkg::osd_clk_ctl_t clk_ctl
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// ==========================================================
	// Assertions
	boot_src_a: assert property (
		!$past(resetn, 2) && $past(resetn) |=>
		clk_ctl.active_source == cfg.initial_osc_select_config)
		else $error("boot source differs from config");
	monitor_on_a: assert property (
		$past(resetn, 2) |-> clk_ctl.failsafe_clock_monitor ==
		(cfg.switch_monitor_config == 2'h0))
		else $error("monitor enable differs from config");
	no_switch_a: assert property (
		$past(resetn, 3) && cfg.switch_monitor_config[1] |->
		$stable(clk_ctl.active_source))
		else $error("source changed with switching disabled");
	pll_run_a: assert property (
		$past(resetn, 3) && clk_ctl.active_source inside {3'h1, 3'h3}
		|-> clk_ctl.pll_enable)
		else $error("pll off in a pll source");
	rc_div_a: assert property (
		clk_ctl.rc_divisor_m1 inside {8'h0, 8'h1, 8'h3, 8'h7, 8'hf,
		8'h1f, 8'h3f, 8'hff})
		else $error("illegal rc divisor");
	sys_div_a: assert property (
		usb_enabled && $past(usb_enabled) &&
		$past(clk_ctl.sys_divisor_m1) < 3'h3 |->
		clk_ctl.sys_divisor_m1 < 3'h3)
		else $error("slow system divisor taken with usb on");
	pin_hold_a: assert property (
		$past(resetn, 3) && !$past(pinmap_unlocked, 2) |->
		$stable(clk_ctl.pin_mapping_lock))
		else $error("pin lock changed while locked");
	one_way_a: assert property (
		cfg.one_way_pinmap_lock_config && $past(clk_ctl.pin_mapping_lock)
		|-> clk_ctl.pin_mapping_lock)
		else $error("one way pin lock cleared");

	// Main scenarios reached
	cover property ($changed(clk_ctl.active_source));
	cover property ($rose(clk_ctl.pll_enable));
	cover property ($rose(clk_ctl.pin_mapping_lock));
endmodule

bind osd_clock_ctrl osd_clock_ctrl_monitor i_mon (.sys_clk(sys_clk),
	.resetn(resetn), .cfg(cfg), .pinmap_unlocked(pinmap_unlocked),
	.usb_enabled(usb_enabled), .clk_ctl(clk_ctl));
`default_nettype wire

// [osd_clock_ctrl_tb_top.sv]
// Self-checking bench for osd_clock_ctrl over its register port.
// Assumes the bound port checker; short PLL timer for simulation.
`timescale 1ns/1ps
`default_nettype none

module osd_clock_ctrl_tb_top;
	// ==========================================================
	// Stimulus signals
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	osd_pkg::osd_cfg_t cfg = '0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic osc_write_unlocked = 1'b1;
	logic pinmap_unlocked = 1'b0;
	logic interrupt_event = 1'b0;
	logic sleep_mode = 1'b0;
	logic usb_enabled = 1'b0;
	logic pll_locked_async = 1'b0;
	logic clock_fail_async = 1'b0;
	osd_pkg::osd_clk_ctl_t clk_ctl;
	int miscompares = 0;
	int cmp_count = 0;
	int i;

	// 125 MHz clock
	always #4 sys_clk = ~sys_clk;

	osd_clock_ctrl #(.PLL_START_CYC(8), .SWITCH_CYC(4)) i_dut (
		.sys_clk(sys_clk), .resetn(resetn), .cfg(cfg),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.osc_write_unlocked(osc_write_unlocked),
		.pinmap_unlocked(pinmap_unlocked),
		.interrupt_event(interrupt_event), .sleep_mode(sleep_mode),
		.usb_enabled(usb_enabled), .pll_locked_async(pll_locked_async),
		.clock_fail_async(clock_fail_async), .clk_ctl(clk_ctl));

	// ==========================================================
	// Tasks
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Reset with a new config word: {monitor, mode, source, one-way}
	task automatic rst(input logic [7:0] c);
		@(posedge sys_clk);
		resetn <= 1'b0;
		cfg <= osd_pkg::osd_cfg_t'(c);
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read, mask, compare; data is sampled mid-cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] m,
		input logic [15:0] e, input string n);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(n, e, reg_rdata & m);
	endtask

	// Clock-tree outputs trail the registers
	task automatic settle;
		repeat (3) @(negedge sys_clk);
	endtask

	task automatic irq;
		@(posedge sys_clk);
		interrupt_event <= 1'b1;
		@(posedge sys_clk);
		interrupt_event <= 1'b0;
	endtask

	// Watchdog far beyond the few hundred cycles the tests need
	initial
	begin
		#100000;
		miscompares++;
		end_sim();
	end

	// ==========================================================
	// Test sequence
	initial
	begin
		// Boot source, status and encodings for every source code
		for (i = 0; i < 8; i++)
		begin
			rst({i[1:0], ~i[1:0], i[2:0], 1'b0});
			rd(4'h0, 16'hffdf, {1'b0, i[2:0], 1'b0, i[2:0], 8'h0}, "osc");
			rd(4'h2, 16'h00ff, {8'h0, i[1:0], ~i[1:0], 2'h1, i[1:0] == 2'h0, ~i[1]}, "stat");
			chk("src", 16'(i[2:0]), 16'(clk_ctl.active_source));
		end
		rst(8'hff);
		rd(4'h0, 16'hffdf, 16'h7700, "erased");
		rd(4'h1, 16'hffff, 16'h3100, "div_rst");
		rd(4'h5, 16'hffff, 16'h0, "unmapped");
		$display("boot test done");

		// Switch into and out of a PLL source
		rst(8'h30);
		wr(4'h0, 16'h0101);
		rd(4'h0, 16'h0021, 16'h0001, "pend");
		repeat (12) @(posedge sys_clk);
		rd(4'h0, 16'hffdf, 16'h1100, "sw1");
		repeat (10) @(posedge sys_clk);
		rd(4'h0, 16'h0020, 16'h0020, "lock");
		chk("pll", 16'h1, 16'(clk_ctl.pll_enable));
		chk("internal_rc_postscaler", 16'h1, 16'(clk_ctl.rc_divisor_m1));
		wr(4'h0, 16'h0201);
		rd(4'h0, 16'h0021, 16'h0001, "unlk");
		repeat (12) @(posedge sys_clk);
		rd(4'h0, 16'hffff, 16'h2200, "sw2");
		settle();
		chk("pll_off", 16'h0, 16'(clk_ctl.pll_enable));
		wr(4'h1, 16'h3120);
		settle();
		chk("pll_on", 16'h1, 16'(clk_ctl.pll_enable));
		// Write lock, sleep enable, set-only selection lock
		@(posedge sys_clk);
		osc_write_unlocked <= 1'b0;
		wr(4'h0, 16'h0085);
		rd(4'h0, 16'hffdf, 16'h2200, "wlock");
		@(posedge sys_clk);
		osc_write_unlocked <= 1'b1;
		sleep_mode <= 1'b1;
		settle();
		chk("pri_off", 16'h0, 16'(clk_ctl.primary_run));
		wr(4'h0, 16'h0206);
		settle();
		chk("pri_on", 16'h1, 16'(clk_ctl.primary_run));
		chk("sec", 16'h1, 16'(clk_ctl.secondary_enable));
		@(posedge sys_clk);
		sleep_mode <= 1'b0;
		wr(4'h0, 16'h0280);
		wr(4'h0, 16'h0201);
		repeat (12) @(posedge sys_clk);
		rd(4'h0, 16'hf781, 16'h2280, "nolock");
		wr(4'h0, 16'h0001);
		repeat (12) @(posedge sys_clk);
		rd(4'h0, 16'hf781, 16'h0080, "nolock2");
		// Synced lock indication beats the start-up timer
		@(posedge sys_clk);
		pll_locked_async <= 1'b1;
		wr(4'h0, 16'h0301);
		repeat (7) @(posedge sys_clk);
		rd(4'h0, 16'h7021, 16'h3020, "sync_lk");
		@(posedge sys_clk);
		pll_locked_async <= 1'b0;
		$display("switch test done");

		// Switching disabled and selections frozen
		rst(8'hb0);
		wr(4'h0, 16'h0200);
		rd(4'h0, 16'h0700, 16'h0200, "new_wr");
		wr(4'h0, 16'h0280);
		wr(4'h0, 16'h0301);
		repeat (12) @(posedge sys_clk);
		rd(4'h0, 16'hf781, 16'h0280, "frozen");
		// Pin-map lock, two-way then one-way
		wr(4'h0, 16'h02c0);
		rd(4'h0, 16'h0040, 16'h0, "pin_lk");
		@(posedge sys_clk);
		pinmap_unlocked <= 1'b1;
		wr(4'h0, 16'h02c0);
		wr(4'h0, 16'h0280);
		rd(4'h0, 16'h0040, 16'h0, "pin_clr");
		rst(8'h31);
		wr(4'h0, 16'h0040);
		wr(4'h0, 16'h0000);
		rd(4'h0, 16'h0040, 16'h0040, "one_way");
		@(posedge sys_clk);
		pinmap_unlocked <= 1'b0;
		$display("lock test done");

		// Clock fail: set by monitor, only cleared by software
		rst(8'h30);
		clock_fail_async <= 1'b1;
		repeat (6) @(posedge sys_clk);
		clock_fail_async <= 1'b0;
		rd(4'h0, 16'h0008, 16'h0008, "cf_set");
		wr(4'h0, 16'h0000);
		wr(4'h0, 16'h0008);
		rd(4'h0, 16'h0008, 16'h0, "cf_clr");
		rst(8'h70);
		clock_fail_async <= 1'b1;
		repeat (6) @(posedge sys_clk);
		clock_fail_async <= 1'b0;
		rd(4'h0, 16'h0008, 16'h0, "cf_off");
		$display("fail test done");

		// Dividers, slowdown and recover-on-interrupt
		for (i = 0; i < 8; i++)
		begin
			wr(4'h1, {1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 6'h0});
			settle();
			chk("doze", 16'(i[2:0]), 16'(clk_ctl.cpu_ratio_log2));
			chk("rc", (i == 7) ? 16'hff : 16'((1 << i) - 1), 16'(clk_ctl.rc_divisor_m1));
			chk("sys", 16'((1 << i[1:0]) - 1), 16'(clk_ctl.sys_divisor_m1));
		end
		wr(4'h1, 16'hd900);
		irq();
		rd(4'h1, 16'hffe0, 16'hd100, "roi");
		chk("ratio", 16'h0, 16'(clk_ctl.cpu_ratio_log2));
		wr(4'h1, 16'h5900);
		irq();
		rd(4'h1, 16'hffe0, 16'h5900, "no_roi");
		wr(4'h1, 16'h3100);
		usb_enabled <= 1'b1;
		wr(4'h1, 16'h31c0);
		settle();
		chk("usb", 16'h0, 16'(clk_ctl.sys_divisor_m1));
		$display("divider test done");
		end_sim();
	end
endmodule
`default_nettype wire
